// >>> verilog/pmbc_pkg.sv
package pmbc_pkg;

  // operating configuration codes on the mode strap
  localparam logic [1:0] MODE_SINGLE = 2'h0; // single-chip
  localparam logic [1:0] MODE_SEP    = 2'h1; // expanded, separate bus
  localparam logic [1:0] MODE_MUX    = 2'h2; // expanded, multiplexed

  // reset values
  localparam logic [7:0] DIR_RESET  = 8'h00; // all lines input
  localparam logic [7:0] DATA_RESET = 8'h00; // output latches clear
  localparam logic [4:0] P2_RO_MASK = 5'h02; // bit 1 never driven from the port latch
  localparam logic [7:0] SEL_PAGE_RESET = 8'h00; // select window page

  // operating configuration
  typedef enum logic [1:0] {
    PMBC_SINGLE,                                  // no external bus
    PMBC_SEP,                                     // separate address/data
    PMBC_MUX                                      // time-shared port three
  } pmbc_mode_t;

  // one cpu bus cycle request
  typedef struct packed {
    logic        valid;                           // cycle in progress
    logic        wr;                              // write when high
    logic [15:0] addr;                            // full address
    logic [7:0]  wdata;                           // write data
  } pmbc_cyc_t;

  // one 8-bit port, three-signal form
  typedef struct packed {
    logic [7:0] dout;                             // driven level
    logic [7:0] oe;                               // high while driving
  } pmbc_pin_t;

  // multiplexed cycle phases
  typedef enum logic [1:0] {
    PMBC_PH_IDLE,                                 // no cycle
    PMBC_PH_ADDR,                                 // address on port three
    PMBC_PH_DATA                                  // data on port three
  } pmbc_phase_t;

endpackage

// >>> verilog/pmbc_port.sv
`timescale 1ns/100ps
// one general purpose port: write-only direction and output latch
module pmbc_port #(
  parameter int WIDTH = 8                         // number of lines
) (
  input  wire logic             ref_clk,          // system clock
  input  wire logic             reset_n,          // async reset, low
  input  wire logic             dir_we,           // write direction
  input  wire logic             data_we,          // write output latch
  input  wire logic [WIDTH-1:0] wdata,            // cpu write data
  input  wire logic [WIDTH-1:0] no_drive,         // lines forced input
  input  wire logic [WIDTH-1:0] pin_in,           // pin levels
  output logic      [WIDTH-1:0] pin_out,          // driven levels
  output logic      [WIDTH-1:0] pin_oe,           // drive enables
  output logic      [WIDTH-1:0] rdata             // value read back
);

  // register set of one port
  typedef struct packed {
    logic [WIDTH-1:0] dir;                        // 1 = output
    logic [WIDTH-1:0] data;                       // output latch
  } pmbc_port_st_t;

  pmbc_port_st_t st;                              // current state
  pmbc_port_st_t next_st;                         // next state

  // direction and latch update
  always_comb begin
    next_st = st;
    if (dir_we) begin
      next_st.dir = wdata;                        // RQ9
    end
    if (data_we) begin
      next_st.data = wdata;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st.dir  <= '0;
      st.data <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs; reads give pins for inputs, latch for outputs, never dir
  assign pin_oe  = st.dir & ~no_drive;            // RQ9
  assign pin_out = st.data;
  assign rdata   = (st.data & pin_oe) | (pin_in & ~pin_oe); // RQ12

endmodule // pmbc_port

// >>> verilog/pmbc_top.sv
`timescale 1ns/100ps
// Summary of operation
// (RQ1) three hardware-strapped operating configurations
// (RQ2) mode alters only ports three and four
// (RQ3) single-chip: no bus, ports three/four plain
// (RQ4) separate mode: port three is data bus
// (RQ5) separate mode: output-direction port-four lines carry address
// (RQ6) separate mode: decoded active-low select, 256 locations
// (RQ7) multiplexed: port three addr/data, four high address
// (RQ8) multiplexed: address strobe for external latch
// (RQ9) port one per-bit direction, one means output
// (RQ10) port two five lines, bit one input only; code still drives it under timer/serial takeover
// (RQ11) timer/serial enables take over port-two lines
// (RQ12) direction registers write-only, never read back
// (RQ13) mode strap captured at reset, held
module pmbc_top #(
  parameter logic [7:0] SEL_PAGE = pmbc_pkg::SEL_PAGE_RESET // select page
) (
  input  wire logic                ref_clk,       // 100 MHz clock
  input  wire logic                reset_n,       // async reset, low
  input  wire logic [1:0]          mode_strap,    // configuration pins
  input  pmbc_pkg::pmbc_cyc_t      cyc,           // internal bus cycle
  input  wire logic [4:0]          port_sel,      // one-hot port access
  input  wire logic                dir_access,    // access is to direction
  output logic      [7:0]          rdata,         // read data to cpu
  output logic                     ext_rd_valid,  // external read done
  input  wire logic [7:0]          p1_in,         // port one pins
  output pmbc_pkg::pmbc_pin_t      p1,            // port one drive
  input  wire logic [4:0]          p2_in,         // port two pins
  output logic      [4:0]          p2_out,        // port two levels
  output logic      [4:0]          p2_oe,         // port two enables
  input  wire logic [4:0]          fn_enable,     // timer/serial own line
  input  wire logic [4:0]          fn_out,        // timer/serial levels
  input  wire logic [4:0]          fn_oe,         // timer/serial enables
  input  wire logic [7:0]          p3_in,         // port three pins
  output pmbc_pkg::pmbc_pin_t      p3,            // port three drive
  input  wire logic [7:0]          p4_in,         // port four pins
  output pmbc_pkg::pmbc_pin_t      p4,            // port four drive
  output logic                     ext_select_n,  // external select, low
  output logic                     addr_latch_strobe, // address strobe
  output logic                     ext_rw         // bus direction, 1 read
);

  // whole block state
  typedef struct packed {
    logic                  captured;              // strap taken
    pmbc_pkg::pmbc_mode_t  mode;                  // held configuration
    pmbc_pkg::pmbc_phase_t phase;                 // mux cycle phase
    logic [15:0]           addr;                  // address of cycle
    logic [7:0]            wdata;                 // write data of cycle
    logic                  wr;                    // write cycle
    logic                  sel;                   // select asserted
    logic                  strobe;                // strobe asserted
    logic [7:0]            rd;                    // captured read data
    logic                  rd_valid;              // read data ready
  } pmbc_st_t;

  pmbc_st_t st;                                   // current state
  pmbc_st_t next_st;                              // next state

  logic [7:0] p1_rd;                              // port one read
  logic [7:0] p2_rd;                              // port two read
  logic [7:0] p3_rd;                              // port three read
  logic [7:0] p4_rd;                              // port four read
  logic [7:0] p3_gp_out;                          // port three latch
  logic [7:0] p3_gp_oe;                           // port three dir
  logic [7:0] p4_gp_out;                          // port four latch
  logic [7:0] p4_gp_oe;                           // port four dir
  logic [4:0] p2_gp_out;                          // port two latch
  logic [4:0] p2_gp_oe;                           // port two dir
  logic [7:0] p2_rd5;                             // padded port two read
  logic       ext_cyc;                            // cycle goes off chip
  logic [4:0] we_dir;                             // direction strobes
  logic [4:0] we_data;                            // latch strobes

  // register strobes from the one-hot port select
  assign we_dir  = port_sel & {5{cyc.valid & cyc.wr & dir_access}};
  assign we_data = port_sel & {5{cyc.valid & cyc.wr & ~dir_access}};

  // cycle leaves the chip only in expanded modes with no port hit
  always_comb begin
    ext_cyc = 1'b0;
    if (cyc.valid && (port_sel == 5'h00)) begin
      case (st.mode)
        pmbc_pkg::PMBC_SEP: begin
          ext_cyc = (cyc.addr[15:8] == SEL_PAGE); // RQ6
        end
        pmbc_pkg::PMBC_MUX: begin
          ext_cyc = 1'b1;                         // RQ7
        end
        default: begin
          ext_cyc = 1'b0;                         // RQ3
        end
      endcase
    end
  end

  // mode capture and external cycle sequencing
  always_comb begin
    next_st          = st;
    next_st.rd_valid = 1'b0;
    if (!st.captured) begin
      next_st.captured = 1'b1;                    // RQ13
      case (mode_strap)
        pmbc_pkg::MODE_SEP: next_st.mode = pmbc_pkg::PMBC_SEP; // RQ1
        pmbc_pkg::MODE_MUX: next_st.mode = pmbc_pkg::PMBC_MUX; // RQ1
        default:            next_st.mode = pmbc_pkg::PMBC_SINGLE; // RQ1
      endcase
    end
    case (st.phase)
      pmbc_pkg::PMBC_PH_IDLE: begin
        next_st.sel    = 1'b0;
        next_st.strobe = 1'b0;
        if (ext_cyc) begin
          next_st.addr   = cyc.addr;
          next_st.wdata  = cyc.wdata;
          next_st.wr     = cyc.wr;
          next_st.phase  = pmbc_pkg::PMBC_PH_ADDR;
          // strobe only in multiplexed mode, select only in separate
          next_st.strobe = (st.mode == pmbc_pkg::PMBC_MUX); // RQ8
          next_st.sel    = (st.mode == pmbc_pkg::PMBC_SEP); // RQ6
        end
      end
      pmbc_pkg::PMBC_PH_ADDR: begin
        next_st.strobe = 1'b0;                    // RQ8
        next_st.phase  = pmbc_pkg::PMBC_PH_DATA;
      end
      pmbc_pkg::PMBC_PH_DATA: begin
        next_st.sel      = 1'b0;
        next_st.phase    = pmbc_pkg::PMBC_PH_IDLE;
        next_st.rd       = p3_in;                 // RQ4
        next_st.rd_valid = ~st.wr;
      end
      default: begin
        next_st.phase = pmbc_pkg::PMBC_PH_IDLE;   // recover
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st.captured <= 1'b0;
      st.mode     <= pmbc_pkg::PMBC_SINGLE;
      st.phase    <= pmbc_pkg::PMBC_PH_IDLE;
      st.addr     <= 16'h0000;
      st.wdata    <= pmbc_pkg::DATA_RESET;
      st.wr       <= 1'b0;
      st.sel      <= 1'b0;
      st.strobe   <= 1'b0;
      st.rd       <= pmbc_pkg::DATA_RESET;
      st.rd_valid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // port one: mode independent
  pmbc_port #(.WIDTH(8)) u_p1 (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .dir_we   (we_dir[0]),
    .data_we  (we_data[0]),
    .wdata    (cyc.wdata),
    .no_drive (8'h00),
    .pin_in   (p1_in),
    .pin_out  (p1.dout),
    .pin_oe   (p1.oe),
    .rdata    (p1_rd)
  );

  // port two: five lines, bit one input only unless timer/serial takes it over
  pmbc_port #(.WIDTH(5)) u_p2 (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .dir_we   (we_dir[1]),
    .data_we  (we_data[1]),
    .wdata    (cyc.wdata[4:0]),
    .no_drive (pmbc_pkg::P2_RO_MASK | fn_enable), // RQ10
    .pin_in   (p2_in),
    .pin_out  (p2_gp_out),
    .pin_oe   (p2_gp_oe),
    .rdata    (p2_rd[4:0])
  );
  assign p2_rd[7:5] = 3'h0;

  // timer and serial take their lines over general data
  assign p2_out = (fn_enable & fn_out) | (~fn_enable & p2_gp_out); // RQ11
  assign p2_oe  = (fn_enable & fn_oe) | p2_gp_oe; // RQ11
  assign p2_rd5 = p2_rd;

  // port three latch and direction, used in single-chip only
  pmbc_port #(.WIDTH(8)) u_p3 (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .dir_we   (we_dir[2]),
    .data_we  (we_data[2]),
    .wdata    (cyc.wdata),
    .no_drive (8'h00),
    .pin_in   (p3_in),
    .pin_out  (p3_gp_out),
    .pin_oe   (p3_gp_oe),
    .rdata    (p3_rd)
  );

  // port four latch and direction
  pmbc_port #(.WIDTH(8)) u_p4 (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .dir_we   (we_dir[3]),
    .data_we  (we_data[3]),
    .wdata    (cyc.wdata),
    .no_drive (8'h00),
    .pin_in   (p4_in),
    .pin_out  (p4_gp_out),
    .pin_oe   (p4_gp_oe),
    .rdata    (p4_rd)
  );

  // port three function by configuration
  always_comb begin
    p3.dout = p3_gp_out;                          // RQ3
    p3.oe   = p3_gp_oe;                           // RQ3
    case (st.mode)
      pmbc_pkg::PMBC_SEP: begin
        p3.dout = st.wdata;                       // RQ4
        p3.oe   = {8{st.sel & st.wr}};            // RQ4
      end
      pmbc_pkg::PMBC_MUX: begin
        if (st.phase == pmbc_pkg::PMBC_PH_ADDR) begin
          p3.dout = st.addr[7:0];                 // RQ7
          p3.oe   = 8'hff;                        // RQ7
        end else begin
          p3.dout = st.wdata;                     // RQ7
          p3.oe   = {8{(st.phase == pmbc_pkg::PMBC_PH_DATA) & st.wr}};
        end
      end
      default: begin
      end
    endcase
  end

  // port four function by configuration
  always_comb begin
    p4.dout = p4_gp_out;                          // RQ3
    p4.oe   = p4_gp_oe;                           // RQ3
    case (st.mode)
      pmbc_pkg::PMBC_SEP: begin
        p4.dout = st.addr[7:0];                   // RQ5
        p4.oe   = p4_gp_oe;                       // RQ5
      end
      pmbc_pkg::PMBC_MUX: begin
        p4.dout = st.addr[15:8];                  // RQ7
        p4.oe   = 8'hff;                          // RQ7
      end
      default: begin
      end
    endcase
  end

  // bus control pins
  assign ext_select_n      = ~st.sel;             // RQ6
  assign addr_latch_strobe = st.strobe;           // RQ8
  assign ext_rw            = ~st.wr | (st.phase == pmbc_pkg::PMBC_PH_IDLE);
  assign ext_rd_valid      = st.rd_valid;

  // read mux; direction registers always read as zero
  always_comb begin
    rdata = 8'h00;                                // RQ12
    if (dir_access) begin
      rdata = 8'h00;                              // RQ12
    end else if (st.rd_valid) begin
      rdata = st.rd;
    end else begin
      case (port_sel)
        5'h01:   rdata = p1_rd;                   // RQ2
        5'h02:   rdata = p2_rd5;                  // RQ2
        5'h04:   rdata = p3_rd;
        5'h08:   rdata = p4_rd;
        default: rdata = 8'h00;
      endcase
    end
  end

endmodule // pmbc_top

// >>> tb/pmbc_props.sv
`timescale 1ns/100ps
// watches the mode, port and bus outputs of the block
module pmbc_props #(
  parameter logic [7:0] SEL_PAGE = 8'h00 // select page
) (
  input wire logic           ref_clk,           // clock
  input wire logic           reset_n,           // reset, low
  input wire logic [1:0]     mode_strap,        // strap pins
  input pmbc_pkg::pmbc_cyc_t cyc,               // bus cycle
  input wire logic [4:0]     port_sel,          // port access
  input wire logic           dir_access,        // direction access
  input wire logic [7:0]     rdata,             // read data
  input wire logic           ext_rd_valid,      // read done
  input pmbc_pkg::pmbc_pin_t p1,                // port one
  input pmbc_pkg::pmbc_pin_t p3,                // port three
  input pmbc_pkg::pmbc_pin_t p4,                // port four
  input wire logic [4:0]     p2_oe,             // port two enables
  input wire logic [4:0]     fn_enable,         // takeover
  input wire logic [4:0]     fn_oe,             // takeover enables
  input wire logic           ext_select_n,      // select, low
  input wire logic           addr_latch_strobe  // address strobe
);
  logic [1:0] mode;  // strap as held by the block
  logic       first; // first edge after reset
  // capture the strap once after reset, as the block does
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode  <= 2'h0;
      first <= 1'b1;
    end else if (first) begin
      mode  <= mode_strap;
      first <= 1'b0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sel_mode_a: assert property (!ext_select_n |-> mode == 2'h1)
    else $error("select outside separate mode");
  strobe_mode_a: assert property (addr_latch_strobe |-> mode == 2'h2)
    else $error("strobe outside multiplexed mode");
  strobe_pulse_a: assert property (addr_latch_strobe
    |=> !addr_latch_strobe)
    else $error("strobe longer than one cycle");
  mux_addr_a: assert property (addr_latch_strobe |-> p3.oe == 8'hff
    && p3.dout == $past(cyc.addr[7:0]) && p4.dout == $past(cyc.addr[15:8]))
    else $error("address phase wrong");
  sel_len_a: assert property ($fell(ext_select_n)
    |-> ##1 !ext_select_n ##1 ext_select_n)
    else $error("select not two cycles");
  sel_page_a: assert property ($fell(ext_select_n) |-> $past(cyc.valid)
    && $past(cyc.addr[15:8]) == SEL_PAGE && $past(port_sel) == 5'h00)
    else $error("select outside window");
  p2_bit1_a: assert property (p2_oe[1] |-> fn_enable[1] && fn_oe[1])
    else $error("port two bit one driven");
  rd_late_a: assert property (ext_rd_valid |->
    $past(addr_latch_strobe, 2) || !$past(ext_select_n))
    else $error("read done without bus cycle");
  dir_wr_a: assert property (cyc.valid && cyc.wr && dir_access
    && port_sel == 5'h01 |=> p1.oe == $past(cyc.wdata))
    else $error("port one direction not taken");
  dir_rd_a: assert property (cyc.valid && !cyc.wr && dir_access
    && port_sel != 5'h00 |-> rdata == 8'h00)
    else $error("direction read back");
  cover property ($fell(ext_select_n));
  cover property (addr_latch_strobe);
  cover property (ext_rd_valid);
endmodule // pmbc_props

bind pmbc_top pmbc_props #(.SEL_PAGE(SEL_PAGE)) props_u (.ref_clk, .reset_n,
  .mode_strap, .cyc, .port_sel, .dir_access, .rdata, .ext_rd_valid, .p1,
  .p3, .p4, .p2_oe, .fn_enable, .fn_oe, .ext_select_n, .addr_latch_strobe);

// >>> tb/pmbc_ext_mem.sv
`timescale 1ns/100ps
// far side: address latch plus a 256-byte memory on port three
module pmbc_ext_mem (
  input wire logic           ref_clk,           // clock
  input pmbc_pkg::pmbc_pin_t p3,                // port three drive
  input pmbc_pkg::pmbc_pin_t p4,                // port four drive
  input wire logic           ext_select_n,      // select, low
  input wire logic           addr_latch_strobe, // address strobe
  input wire logic           ext_rw,            // 1 read
  output logic [7:0]         p3_in              // resolved port three
);
  logic [7:0] mem [256];    // storage
  logic [7:0] lat;          // latched low address
  logic [7:0] last = 8'h00; // previous wire level
  logic       dph = 1'b0;   // multiplexed data phase
  wire        sel = !ext_select_n;
  wire  [7:0] idx = sel ? (p4.dout & p4.oe) : lat;
  wire        drv = (sel || dph) && ext_rw && p3.oe == 8'h00;
  // latch address, store writes, remember level
  always_ff @(posedge ref_clk) begin
    dph <= addr_latch_strobe;
    if (addr_latch_strobe) begin
      lat <= p3.dout;
    end
    if ((sel || dph) && !ext_rw && p3.oe == 8'hff) begin
      mem[idx] <= p3.dout;
    end
    last <= p3_in;
  end
  // released wire shows the inverse of its last level
  assign p3_in = (p3.dout & p3.oe) | ((drv ? mem[idx] : ~last) & ~p3.oe);
endmodule // pmbc_ext_mem

// >>> tb/test_port_mode_bus_config.sv
`timescale 1ns/100ps
// self-checking bench for the port and mode block
module test_port_mode_bus_config;
  localparam logic [7:0] PAGE = 8'h20; // window page under test
  logic                ref_clk = 1'b0;       // clock
  logic                reset_n = 1'b0;       // reset, low
  logic [1:0]          mode_strap = 2'h0;    // strap
  pmbc_pkg::pmbc_cyc_t cyc = '0;             // bus cycle
  logic [4:0]          port_sel = 5'h00;     // port access
  logic                dir_access = 1'b0;    // direction access
  logic [4:0]          fn_enable = 5'h00;    // takeover
  logic [4:0]          fn_out = 5'h00;       // takeover levels
  logic [4:0]          fn_oe = 5'h00;        // takeover enables
  logic [7:0]          pin_drv = 8'h96;      // far level on inputs
  logic [7:0]          rdata, p1_in, p3_in, p4_in;
  logic                ext_rd_valid, ext_select_n;
  logic                addr_latch_strobe, ext_rw;
  pmbc_pkg::pmbc_pin_t p1, p3, p4;
  logic [4:0]          p2_in, p2_out, p2_oe;
  int                  num_errors = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  // wire levels from both parties' enables
  assign p1_in = (p1.dout & p1.oe) | (pin_drv & ~p1.oe);
  assign p2_in = (p2_out & p2_oe) | (pin_drv[4:0] & ~p2_oe);
  assign p4_in = (p4.dout & p4.oe) | (pin_drv & ~p4.oe);
  pmbc_top #(.SEL_PAGE(PAGE)) dut_u (.ref_clk, .reset_n, .mode_strap,
    .cyc, .port_sel, .dir_access, .rdata, .ext_rd_valid, .p1_in, .p1,
    .p2_in, .p2_out, .p2_oe, .fn_enable, .fn_out, .fn_oe, .p3_in, .p3,
    .p4_in, .p4, .ext_select_n, .addr_latch_strobe, .ext_rw);
  pmbc_ext_mem mem_u (.ref_clk, .p3, .p4, .ext_select_n,
    .addr_latch_strobe, .ext_rw, .p3_in);
  // clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %0t %s %h %h", $time, what, got, exp);
    end
  endtask
  // reset with a strap value, wait until requests are allowed
  task automatic start(input logic [1:0] m);
    @(posedge ref_clk);
    #1 reset_n = 1'b0;
    mode_strap = m;
    repeat (5) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic req(input logic wr, input logic [4:0] sel,
                     input logic dir, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    #1 cyc = '{1'b1, wr, a, d};
    port_sel = sel;
    dir_access = dir;
  endtask
  task automatic idle;
    @(posedge ref_clk);
    #1 cyc.valid = 1'b0;
    port_sel = 5'h00;
  endtask
  task automatic pwr(input logic [4:0] sel, input logic dir,
                     input logic [7:0] d);
    req(1'b1, sel, dir, 16'h0000, d);
    idle();
  endtask
  task automatic prd(input logic [4:0] sel, input logic dir,
                     input logic [7:0] exp);
    req(1'b0, sel, dir, 16'h0000, 8'h00);
    #1 chk(rdata, exp, "port read");
    idle();
  endtask
  // one external cycle; hit says whether the bus must run
  task automatic ext(input logic wr, input logic [15:0] a,
                     input logic [7:0] d, input logic hit);
    req(wr, 5'h00, 1'b0, a, d);
    idle();
    chk({7'h0, !ext_select_n | addr_latch_strobe}, {7'h0, hit}, "go");
    chk({7'h0, ext_rw}, {7'h0, !(hit && wr)}, "bus dir");
    if (hit && wr && mode_strap == 2'h1) begin
      chk(p3.dout & p3.oe, d, "data bus");
      chk(p4.dout & p4.oe, a[7:0] & 8'h0f, "low address");
    end
    repeat (2) idle();
    if (!wr) chk({7'h0, ext_rd_valid}, {7'h0, hit}, "done");
    if (!wr && hit) chk(rdata, d, "read data");
  endtask
  task automatic t_port1(input logic [1:0] m);
    start(m);
    pwr(5'h01, 1'b1, 8'ha5);
    pwr(5'h01, 1'b0, 8'h3c);
    chk(p1.oe, 8'ha5, "p1 dir");
    chk(p1.dout & 8'ha5, 8'h3c & 8'ha5, "p1 out");
    prd(5'h01, 1'b0, (8'h3c & 8'ha5) | (pin_drv & 8'h5a));
    prd(5'h01, 1'b1, 8'h00);
  endtask
  task automatic t_port2;
    start(2'h0);
    pwr(5'h02, 1'b1, 8'hff);
    pwr(5'h02, 1'b0, 8'hff);
    chk({3'h0, p2_oe}, 8'h1d, "p2 dir");
    prd(5'h02, 1'b0, 8'h1d | (pin_drv & 8'h02));
    fn_enable = 5'h1f;
    fn_out = 5'h0a;
    fn_oe = 5'h12;
    idle();
    chk({3'h0, p2_oe}, 8'h12, "take oe");
    chk({3'h0, p2_out & p2_oe}, 8'h02, "take out");
    fn_enable = 5'h00;
  endtask
  task automatic t_single(input logic [1:0] m);
    start(m);
    ext(1'b1, {PAGE, 8'h37}, 8'hc4, 1'b0);
    ext(1'b0, {PAGE, 8'h37}, 8'hc4, 1'b0);
    pwr(5'h04, 1'b1, 8'hff);
    pwr(5'h04, 1'b0, 8'h5a);
    chk(p3.oe & p3.dout, 8'h5a, "p3 port");
    prd(5'h04, 1'b0, 8'h5a);
  endtask
  task automatic t_sep;
    start(2'h1);
    pwr(5'h08, 1'b1, 8'h0f);
    ext(1'b1, {PAGE, 8'h37}, 8'hc4, 1'b1);
    ext(1'b0, {PAGE, 8'h37}, 8'hc4, 1'b1);
    ext(1'b1, {8'h21, 8'h37}, 8'h11, 1'b0);
    chk(p4.oe, 8'h0f, "p4 dir");
    prd(5'h08, 1'b0, pin_drv & 8'hf0);
  endtask
  task automatic t_mux;
    start(2'h2);
    #1 mode_strap = 2'h0;
    ext(1'b1, 16'h4a21, 8'h9e, 1'b1);
    ext(1'b1, 16'hb5de, 8'h61, 1'b1);
    ext(1'b0, 16'h4a21, 8'h9e, 1'b1);
    ext(1'b0, 16'hb5de, 8'h61, 1'b1);
  endtask
  // main sequence
  initial begin
    for (int m = 0; m < 3; m++) begin
      t_port1(m[1:0]);
    end
    t_port2();
    t_single(2'h0);
    t_single(2'h3);
    t_sep();
    t_mux();
    stop_test();
  end
endmodule // test_port_mode_bus_config
